/* rtl/iptm_pkg.sv */
// Package for the I/O pin test multiplexer: widths, reset values, modes
package iptm_pkg;
	localparam int IPTM_WIDTH = 8;
	localparam int IPTM_SEL_BIT = 0;
	localparam logic [7:0] IPTM_CNT_RESET = 8'h00;
	localparam logic [7:0] IPTM_CNT_STEP = 8'h01;
	localparam logic [7:0] IPTM_OE_OFF = 8'h00;
	localparam logic [7:0] IPTM_OE_ON = 8'hFF;
	localparam logic [2:0] IPTM_SYNC_RESET = 3'h0;
	typedef enum logic [1:0] {
		IPTM_MODE_IN_MIRROR,
		IPTM_MODE_BIDIR_MIRROR,
		IPTM_MODE_COUNTER
	} iptm_mode_t;
endpackage : iptm_pkg

/* rtl/iptm_io_pin_test_mux.sv */
// I/O pin test multiplexer: input mirror, bidirectional mirror and counter modes
`timescale 1ns/100ps

module iptm_io_pin_test_mux
	import iptm_pkg::*;
#(
	parameter int WIDTH = IPTM_WIDTH
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] dedicated_inputs_i,
	input wire logic [WIDTH-1:0] bidir_i,
	output logic [WIDTH-1:0] dedicated_outputs_o,
	output logic [WIDTH-1:0] bidir_o,
	output logic [WIDTH-1:0] bidir_oe_o
);

	////////////////////////////////////////////////////////////////////////
	// Pin input synchronisers; both pin groups are outside the clock domain
	logic [WIDTH-1:0] din_sync;
	logic [WIDTH-1:0] bin_sync;

	iptm_pin_sync #(
		.WIDTH(WIDTH)
	) u_din_sync (
		.ref_clk_i(ref_clk_i),
		.pin_i(dedicated_inputs_i),
		.level_o(din_sync)
	);

	iptm_pin_sync #(
		.WIDTH(WIDTH)
	) u_bin_sync (
		.ref_clk_i(ref_clk_i),
		.pin_i(bidir_i),
		.level_o(bin_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// Mode decode and counter
	iptm_mode_t mode;
	logic [WIDTH-1:0] cnt_val;

	// Reset is read as a level so the mirror mode needs no clock edge to start
	always_comb begin
		if (!rst_n_i) begin
			mode = IPTM_MODE_IN_MIRROR;
		end else if (din_sync[IPTM_SEL_BIT]) begin
			mode = IPTM_MODE_COUNTER;
		end else begin
			mode = IPTM_MODE_BIDIR_MIRROR;
		end
	end

	iptm_free_counter #(
		.WIDTH(WIDTH)
	) u_free_counter (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.count_o(cnt_val)
	);

	////////////////////////////////////////////////////////////////////////
	// Pin data registers; not reset so input mirroring works during reset
	logic [WIDTH-1:0] out_reg;
	logic [WIDTH-1:0] out_next;
	logic [WIDTH-1:0] bout_reg;
	logic [WIDTH-1:0] bout_next;

	always_comb begin
		case (mode)
			IPTM_MODE_IN_MIRROR: begin
				out_next = din_sync;
				bout_next = WIDTH'(IPTM_CNT_RESET);
			end
			IPTM_MODE_BIDIR_MIRROR: begin
				out_next = bin_sync;
				bout_next = WIDTH'(IPTM_CNT_RESET);
			end
			IPTM_MODE_COUNTER: begin
				out_next = cnt_val;
				bout_next = cnt_val;
			end
			// Unknown mode falls back to the safe mirror
			default: begin
				out_next = din_sync;
				bout_next = WIDTH'(IPTM_CNT_RESET);
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		out_reg <= out_next;
		bout_reg <= bout_next;
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drive enable
	logic [WIDTH-1:0] boe_reg;
	logic [WIDTH-1:0] boe_next;

	always_comb begin
		case (mode)
			IPTM_MODE_IN_MIRROR: begin
				boe_next = WIDTH'(IPTM_OE_OFF);
			end
			IPTM_MODE_BIDIR_MIRROR: begin
				boe_next = WIDTH'(IPTM_OE_OFF);
			end
			IPTM_MODE_COUNTER: begin
				boe_next = WIDTH'(IPTM_OE_ON);
			end
			default: begin
				boe_next = WIDTH'(IPTM_OE_OFF);
			end
		endcase
	end

	// Enable must drop at once on reset to avoid contention with the tester
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			boe_reg <= WIDTH'(IPTM_OE_OFF);
		end else begin
			boe_reg <= boe_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Every output comes straight from a flip-flop
	assign dedicated_outputs_o = out_reg;
	assign bidir_o = bout_reg;
	assign bidir_oe_o = boe_reg;

endmodule : iptm_io_pin_test_mux

////////////////////////////////////////////////////////////////////////
// Three-stage pin synchroniser; a change counts once stages two and three agree
module iptm_pin_sync
	import iptm_pkg::*;
#(
	parameter int WIDTH = IPTM_WIDTH
) (
	input wire logic ref_clk_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o
);

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage3_reg;
	logic [WIDTH-1:0] level_reg;
	logic [WIDTH-1:0] stage1_next;
	logic [WIDTH-1:0] stage2_next;
	logic [WIDTH-1:0] stage3_next;
	logic [WIDTH-1:0] level_next;

	// Only stage two reads stage one, which may go metastable
	always_comb begin
		stage1_next = pin_i;
		stage2_next = stage1_reg;
		stage3_next = stage2_reg;
		level_next = level_reg;
		for (int i = 0; i < WIDTH; i++) begin
			// One-cycle glitches never reach the core
			if (stage2_reg[i] == stage3_reg[i]) begin
				level_next[i] = stage3_reg[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// No reset: the mirror path must keep running while reset is low
	always_ff @(posedge ref_clk_i) begin
		stage1_reg <= stage1_next;
		stage2_reg <= stage2_next;
		stage3_reg <= stage3_next;
		level_reg <= level_next;
	end

	assign level_o = level_reg;

endmodule : iptm_pin_sync

////////////////////////////////////////////////////////////////////////
// Free-running counter, cleared while reset is low
module iptm_free_counter
	import iptm_pkg::*;
#(
	parameter int WIDTH = IPTM_WIDTH
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	output logic [WIDTH-1:0] count_o
);

	logic [WIDTH-1:0] cnt_reg;
	logic [WIDTH-1:0] cnt_next;

	// Natural wrap at the top value, no terminal count needed
	always_comb begin
		cnt_next = cnt_reg + WIDTH'(IPTM_CNT_STEP);
	end

	////////////////////////////////////////////////////////////////////////
	// Asynchronous clear so counting restarts from zero on release
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= WIDTH'(IPTM_CNT_RESET);
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign count_o = cnt_reg;

endmodule : iptm_free_counter

/* tb/iptm_checker.sv */
// Checker for the pin test multiplexer
`timescale 1ns/100ps
module iptm_checker #(parameter int WIDTH = 8) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] dedicated_inputs_i,
	input wire logic [WIDTH-1:0] dedicated_outputs_o,
	input wire logic [WIDTH-1:0] bidir_o,
	input wire logic [WIDTH-1:0] bidir_oe_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire on = &bidir_oe_o;
	sequence sel_lo; !dedicated_inputs_i[0] [*8]; endsequence
	oe_whole_a: assert property (on || !bidir_oe_o) else $error("oe split");
	cnt_both_a: assert property (on |-> dedicated_outputs_o == bidir_o) else $error("out");
	cnt_step_a: assert property (on && $past(on) |-> bidir_o == WIDTH'($past(bidir_o) + 1'b1)) else $error("step");
	sel_off_a: assert property (sel_lo |-> !bidir_oe_o) else $error("off");
	sel_on_a: assert property (dedicated_inputs_i[0] [*8] |-> on) else $error("on");
	cnt_clear_a: assert property ($rose(rst_n_i) ##1 on |-> !bidir_o) else $error("clr");
endmodule : iptm_checker
bind iptm_io_pin_test_mux iptm_checker #(.WIDTH(WIDTH)) u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.dedicated_inputs_i(dedicated_inputs_i), .dedicated_outputs_o(dedicated_outputs_o), .bidir_o(bidir_o),
	.bidir_oe_o(bidir_oe_o));

/* tb/iptm_tester.sv */
// Test equipment driving the pins
`timescale 1ns/100ps
module iptm_tester (
	output logic [7:0] a_o,
	output logic [7:0] b_o
);
	initial {a_o, b_o} = 16'h0000;
	task automatic put(input logic [15:0] v);
		{a_o, b_o} = v;
	endtask : put
endmodule : iptm_tester

/* tb/testbench.sv */
// Testbench for the pin test multiplexer
`timescale 1ns/100ps
module testbench;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] a, b, q, bo, oe;
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	// Device wins the pad while it drives
	wire [7:0] pad = (oe & bo) | (~oe & b);
	always #5 ref_clk_i = ~ref_clk_i;
	iptm_tester u_iptm_tester (.a_o(a), .b_o(b));
	iptm_io_pin_test_mux u_iptm_io_pin_test_mux (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .dedicated_inputs_i(a),
		.bidir_i(pad), .dedicated_outputs_o(q), .bidir_o(bo), .bidir_oe_o(oe));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic go(input logic r, input logic [15:0] v, input int n);
		rst_n_i = r;
		u_iptm_tester.put(v);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : go
	task automatic t_mirror;
		go(0, 16'hA53C, 8);
		chk(q, 8'hA5);
		chk(oe, 8'h00);
		go(0, 16'h5AC3, 8);
		chk(q, 8'h5A);
		go(1, 16'h5AC3, 8);
		chk(q, 8'hC3);
		chk(oe, 8'h00);
		$display("mirror done");
	endtask : t_mirror
	task automatic t_count;
		go(0, 16'h8100, 8);
		go(1, 16'h8100, 1);
		for (int k = 0; k < 260; k++) begin
			chk(q, 8'(k));
			chk(pad, 8'(k));
			go(1, 16'h8100, 1);
		end
		$display("counter done");
	endtask : t_count
	task automatic conclude;
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude
	initial begin
		go(0, 16'h0000, 3);
		t_mirror();
		t_count();
		conclude();
	end
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 1000) begin
			num_errors++;
			conclude();
		end
	end
endmodule : testbench
